// ==== hdl/charger_pkg.sv ====
package charger_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 10;
   // Typical oscillator period with the usual timing capacitor, in ns.
   localparam int TOSC_NS = 3000000;
   localparam int TOSC_CYCLES = TOSC_NS / CLK_PERIOD_NS;
   localparam int SAFETY_STAGES = 22;
   localparam int QUAL_TICKS = 15;
   localparam int PRE_LIMIT_SHIFT = 3;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [7:0] OSC_DIV_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] TIMER_OFFSET = 8'h08;
   localparam int OSC_DIV_WIDTH = 24;

   // Status register fields.
   localparam int ST_STATE_LSB = 0;
   localparam int ST_COMPLETE_BIT = 8;
   localparam int ST_TIME_FAULT_BIT = 9;
   localparam int ST_CHARGE_ON_BIT = 10;
   localparam int ST_QUAL_LSB = 12;
   localparam int ST_FLAGS_LSB = 16;

   typedef enum logic [5:0] {
      ST_OFF = 6'h01,
      ST_PRE = 6'h02,
      ST_CC = 6'h04,
      ST_CV = 6'h08,
      ST_DONE = 6'h10,
      ST_FAULT = 6'h20
   } chg_state_t;

endpackage : charger_pkg

// ==== hdl/osc_tick_gen.sv ====
`timescale 1ns/1ps

module osc_tick_gen #(
   parameter int WIDTH = 24
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic run,
   input wire logic [WIDTH-1:0] period,
   output logic tick
);

   logic [WIDTH-1:0] count_reg;
   logic at_end;

   // A period of zero behaves as one so the tick never stops.
   assign at_end = (count_reg + 1'b1 >= period) || (period == '0);

   always_ff @(posedge clk_sys) begin
      if (!resetn || !run) begin
         count_reg <= '0;
      end else if (at_end) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn || !run) begin
         tick <= 1'b0;
      end else begin
         tick <= at_end;
      end
   end

endmodule : osc_tick_gen

// ==== hdl/charge_sequencer.sv ====
`timescale 1ns/1ps

module charge_sequencer
   import charger_pkg::*;
#(
   parameter int TIMER_BITS = SAFETY_STAGES,
   parameter int OSC_CYCLES = TOSC_CYCLES
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic enable_pin,
   input wire logic above_precharge_threshold,
   input wire logic above_recharge_threshold,
   input wire logic at_final_charge_voltage,
   input wire logic current_below_eoc,
   input wire logic current_program_pin_fault,
   input wire logic temp_out_of_window,
   input wire logic charge_state_flag_n_in,
   output logic charge_state_flag_n_out,
   output logic charge_state_flag_n_oe,
   input wire logic fault_flag_n_in,
   output logic fault_flag_n_out,
   output logic fault_flag_n_oe,
   output logic bias_rail_output,
   output logic charge_on,
   output logic precharge_mode,
   output logic cv_mode
);

   // ***************************************************************
   // Oscillator and state
   // ***************************************************************
   localparam logic [TIMER_BITS:0] PRE_LIMIT = (TIMER_BITS+1)'(1) << (TIMER_BITS - PRE_LIMIT_SHIFT);
   localparam logic [3:0] QUAL_LAST = 4'(QUAL_TICKS - 1);

   chg_state_t state_reg;
   chg_state_t state_next;
   logic [OSC_DIV_WIDTH-1:0] osc_div_reg;
   logic [TIMER_BITS:0] timer_reg;
   logic [3:0] qual_reg;
   logic complete_reg;
   logic time_fault_reg;
   logic en_prev_reg;
   logic tick;
   logic start_cycle;
   logic charging;
   logic paused;
   logic timer_expired;
   logic pre_expired;

   osc_tick_gen #(
      .WIDTH(OSC_DIV_WIDTH)
   ) u_osc (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .run(enable_pin),
      .period(osc_div_reg),
      .tick(tick)
   );

   assign charging = (state_reg == ST_PRE) || (state_reg == ST_CC) || (state_reg == ST_CV);
   assign paused = temp_out_of_window;
   assign timer_expired = timer_reg[TIMER_BITS];
   assign pre_expired = timer_reg >= PRE_LIMIT;

   assign start_cycle = enable_pin && ((state_reg == ST_OFF)
      || (state_reg == ST_DONE && !above_recharge_threshold));

   // ***************************************************************
   // Sequence
   // ***************************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (start_cycle) begin
               state_next = ST_PRE;
            end
         end
         ST_PRE: begin
            if (pre_expired) begin
               state_next = ST_FAULT;
            end else if (tick && !paused && above_precharge_threshold && qual_reg == QUAL_LAST) begin
               state_next = ST_CC;
            end
         end
         ST_CC: begin
            if (timer_expired) begin
               state_next = complete_reg ? ST_DONE : ST_FAULT;
            end else if (at_final_charge_voltage) begin
               state_next = ST_CV;
            end
         end
         ST_CV: begin
            if (timer_expired) begin
               state_next = complete_reg ? ST_DONE : ST_FAULT;
            end
         end
         ST_DONE: begin
            if (start_cycle) begin
               state_next = ST_PRE;
            end
         end
         ST_FAULT: begin
            state_next = ST_FAULT;
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn || !enable_pin) begin
         state_reg <= ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         en_prev_reg <= 1'b0;
      end else begin
         en_prev_reg <= enable_pin;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn || state_reg != ST_PRE) begin
         qual_reg <= 4'h0;
      end else if (tick && !paused) begin
         qual_reg <= above_precharge_threshold ? qual_reg + 4'h1 : 4'h0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn || !enable_pin || start_cycle) begin
         timer_reg <= '0;
      end else if (charging && tick && !paused && !timer_expired) begin
         timer_reg <= timer_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn || !enable_pin || start_cycle) begin
         complete_reg <= 1'b0;
      end else if ((state_reg == ST_CC || state_reg == ST_CV) && above_recharge_threshold
                   && current_below_eoc && !paused) begin
         complete_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn || !enable_pin) begin
         time_fault_reg <= 1'b0;
      end else if (state_next == ST_FAULT) begin
         time_fault_reg <= 1'b1;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         charge_on <= 1'b0;
         precharge_mode <= 1'b0;
         cv_mode <= 1'b0;
         bias_rail_output <= 1'b0;
         charge_state_flag_n_oe <= 1'b0;
         fault_flag_n_oe <= 1'b0;
      end else begin
         charge_on <= (state_next == ST_PRE || state_next == ST_CC || state_next == ST_CV)
            && !current_program_pin_fault && !paused && enable_pin;
         precharge_mode <= state_next == ST_PRE;
         cv_mode <= state_next == ST_CV;
         bias_rail_output <= enable_pin;
         charge_state_flag_n_oe <= enable_pin && !complete_reg && (state_next == ST_PRE
            || state_next == ST_CC || state_next == ST_CV) && !current_program_pin_fault && !paused;
         fault_flag_n_oe <= enable_pin && (state_next == ST_FAULT
            || (current_program_pin_fault || paused) && state_next != ST_OFF);
      end
   end

   // Open-drain pins only ever pull low; the board pull-up makes the high.
   assign charge_state_flag_n_out = 1'b0;
   assign fault_flag_n_out = 1'b0;

   // ***************************************************************
   // AHB-Lite slave
   // ***************************************************************
   logic ph_valid_reg;
   logic ph_write_reg;
   logic [7:0] ph_addr_reg;
   logic [31:0] status_word;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ph_valid_reg <= 1'b0;
         ph_write_reg <= 1'b0;
         ph_addr_reg <= 8'h00;
      end else begin
         ph_valid_reg <= hsel && hready && htrans[1];
         ph_write_reg <= hwrite;
         ph_addr_reg <= haddr[7:0];
      end
   end

   // Oscillator divider stands in for the timing capacitor value.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         osc_div_reg <= OSC_DIV_WIDTH'(OSC_CYCLES);
      end else if (ph_valid_reg && ph_write_reg && ph_addr_reg == OSC_DIV_OFFSET) begin
         osc_div_reg <= hwdata[OSC_DIV_WIDTH-1:0];
      end
   end

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ST_STATE_LSB +: 6] = state_reg;
      status_word[ST_COMPLETE_BIT] = complete_reg;
      status_word[ST_TIME_FAULT_BIT] = time_fault_reg;
      status_word[ST_CHARGE_ON_BIT] = charge_on;
      status_word[ST_QUAL_LSB +: 4] = qual_reg;
      status_word[ST_FLAGS_LSB +: 2] = {fault_flag_n_in, charge_state_flag_n_in};
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            OSC_DIV_OFFSET: begin
               hrdata <= 32'(osc_div_reg);
            end
            STATUS_OFFSET: begin
               hrdata <= status_word;
            end
            TIMER_OFFSET: begin
               hrdata <= 32'(timer_reg);
            end
            default: begin
               hrdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   AST_PRE_CURRENT: assert property (charge_on && precharge_mode |-> $past(state_next) == ST_PRE)
      else $error("Precharge current outside precharge.");
   AST_QUAL_EXIT: assert property ($rose(state_reg == ST_CC) && $past(state_reg) == ST_PRE
      |-> $past(qual_reg) == QUAL_LAST)
      else $error("Precharge left before fifteen ticks.");
   AST_QUAL_CLEAR: assert property (state_reg == ST_PRE && tick && !paused && !above_precharge_threshold
      && !pre_expired |=> qual_reg == 4'h0 && state_reg != ST_CC)
      else $error("Qualification count not cleared.");
   AST_CV_ENTRY: assert property (state_reg == ST_CC && at_final_charge_voltage && !timer_expired
      && enable_pin |=> state_reg == ST_CV)
      else $error("Constant voltage not entered.");
   AST_COMPLETE_CAUSE: assert property ($rose(complete_reg) |-> $past(above_recharge_threshold)
      && $past(current_below_eoc))
      else $error("Completion without its condition.");
   AST_FLAG_LATCH: assert property (complete_reg && charging && enable_pin |=> charge_state_flag_n_oe == 1'b0)
      else $error("State flag pulled after completion.");
   AST_KEEP_CHARGING: assert property (state_reg == ST_CV && complete_reg && !timer_expired && enable_pin
      |=> state_reg == ST_CV)
      else $error("Charging stopped before the timer ran out.");
   AST_TIMER_STEP: assert property (charging && tick && !paused && !timer_expired && !start_cycle && enable_pin
      |=> timer_reg == $past(timer_reg) + 1'b1)
      else $error("Safety timer did not advance.");
   AST_TIMEOUT_FAULT: assert property ((state_reg == ST_CC || state_reg == ST_CV) && timer_expired && !complete_reg
      && enable_pin |=> state_reg == ST_FAULT ##1 fault_flag_n_oe)
      else $error("Timeout did not raise a fault.");
   AST_PRE_LIMIT: assert property (state_reg == ST_PRE && pre_expired && enable_pin |=> time_fault_reg)
      else $error("Precharge limit not enforced.");
   AST_FAULT_HOLDS: assert property (state_reg == ST_FAULT && enable_pin |=> state_reg == ST_FAULT)
      else $error("Time fault released without enable cycle.");
   AST_CURRENT_PROGRAM_PIN_OFF: assert property (current_program_pin_fault |=> !charge_on)
      else $error("Charging with program pin fault.");
   AST_POWER_START: assert property (state_reg == ST_OFF && enable_pin |=> state_reg == ST_PRE
      ##1 bias_rail_output == $past(enable_pin)
      && charge_state_flag_n_oe == $past(enable_pin && !paused && !current_program_pin_fault))
      else $error("Cycle did not start on supply.");
   AST_RECHARGE: assert property (state_reg == ST_DONE && !above_recharge_threshold && enable_pin
      |=> state_reg == ST_PRE && timer_reg == '0)
      else $error("Recharge did not restart the cycle.");
   AST_TEMP_PAUSE: assert property (paused && enable_pin && !start_cycle && state_reg != ST_OFF
      |=> !charge_on && timer_reg == $past(timer_reg)
      ##0 fault_flag_n_oe)
      else $error("Temperature fault did not pause.");
   AST_ENABLE_LOW: assert property (!enable_pin |=> state_reg == ST_OFF && timer_reg == '0 && !charge_on)
      else $error("Enable low did not hold reset.");
   AST_ENABLE_RESTART: assert property (enable_pin && !en_prev_reg |-> start_cycle)
      else $error("Enable release did not start a cycle.");

   COV_QUALIFY: cover property (state_reg == ST_PRE ##1 state_reg == ST_CC);
   COV_COMPLETE: cover property ($rose(complete_reg));
   COV_DONE: cover property (state_reg == ST_CV ##1 state_reg == ST_DONE);
   COV_FAULT: cover property ($rose(time_fault_reg));

endmodule : charge_sequencer

// ==== tb/battery_model.sv ====
`timescale 1ns/1ps
// ******************************************
// Cell and adapter seen from the charger pins
// ******************************************
module battery_model (
   input wire logic clk_sys,
   input wire logic charge_state_flag_n_oe,
   input wire logic fault_flag_n_oe,
   output logic above_precharge_threshold,
   output logic above_recharge_threshold,
   output logic at_final_charge_voltage,
   output logic current_below_eoc,
   output logic enable_pin,
   output logic charge_state_flag_n_in,
   output logic fault_flag_n_in
);
   // Cell level: 0 deep discharge, 1 above precharge, 2 above recharge, 3 at final voltage.
   int level;
   logic taper;
   assign above_precharge_threshold = level >= 1;
   assign above_recharge_threshold = level >= 2;
   assign at_final_charge_voltage = level >= 3;
   // Taper is commanded by the bench so that a low current can be shown below recharge.
   assign current_below_eoc = taper;
   // Both flags are open drain with board pull-ups, so a released pin reads high.
   assign charge_state_flag_n_in = !charge_state_flag_n_oe;
   assign fault_flag_n_in = !fault_flag_n_oe;
   // The charger starts shut down so the divider can be set before a cycle starts.
   initial begin
      level = 0;
      taper = 1'b0;
      enable_pin = 1'b0;
   end

   task set_level(input int v);
      @(posedge clk_sys);
      level <= v;
   endtask : set_level

   task set_taper(input logic v);
      @(posedge clk_sys);
      taper <= v;
   endtask : set_taper

   task set_enable(input logic v);
      @(posedge clk_sys);
      enable_pin <= v;
   endtask : set_enable
endmodule : battery_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
   import charger_pkg::*;
   // ******************************************
   // Bench signals and design
   // ******************************************
   // Short oscillator and timer keep a full cycle near a thousand clocks.
   localparam int OSC = 4;
   localparam int TB = 8;
   logic clk_sys = 1'b0;
   logic resetn, hsel, hwrite, current_program_pin_fault, temp_out_of_window;
   logic [31:0] haddr, hwdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hrdata;
   logic hreadyout, hresp, enable_pin, above_precharge_threshold, above_recharge_threshold;
   logic at_final_charge_voltage, current_below_eoc, charge_state_flag_n_in, charge_state_flag_n_out;
   logic charge_state_flag_n_oe, fault_flag_n_in, fault_flag_n_out, fault_flag_n_oe;
   logic bias_rail_output, charge_on, precharge_mode, cv_mode;
   int num_errors = 0;
   int n_compared = 0;
   int m_state = 0;
   int seed = 32'he7a61040;
   int i, n;
   bit m_done = 1'b0;
   bit m_ext = 1'b0;
   logic [31:0] rd, rnd, t0;

   always #5 clk_sys = ~clk_sys;

   charge_sequencer #(.TIMER_BITS(TB), .OSC_CYCLES(OSC)) charge_sequencer_inst (.clk_sys, .resetn, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .enable_pin,
      .above_precharge_threshold, .above_recharge_threshold, .at_final_charge_voltage, .current_below_eoc,
      .current_program_pin_fault, .temp_out_of_window, .charge_state_flag_n_in, .charge_state_flag_n_out,
      .charge_state_flag_n_oe, .fault_flag_n_in, .fault_flag_n_out, .fault_flag_n_oe, .bias_rail_output,
      .charge_on, .precharge_mode, .cv_mode);

   battery_model battery_model_inst (.clk_sys, .charge_state_flag_n_oe, .fault_flag_n_oe,
      .above_precharge_threshold, .above_recharge_threshold, .at_final_charge_voltage, .current_below_eoc,
      .enable_pin, .charge_state_flag_n_in, .fault_flag_n_in);

   // ******************************************
   // Checking and bus tasks
   // ******************************************
   task summarize;
      $display("errors %0d, compares %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
      end
   endtask : check

   function logic sig(input int k);
      case (k)
         0: return charge_on;
         1: return precharge_mode;
         2: return cv_mode;
         3: return charge_state_flag_n_oe;
         default: return fault_flag_n_oe;
      endcase
   endfunction : sig

   // Every wait is bounded; running out of it ends the run as a failure.
   task wait_sig(input int k, input logic v, input int lim);
      int c;
      for (c = 0; c < lim && sig(k) !== v; c++) @(posedge clk_sys);
      check(c < lim, 1, "wait bound");
      if (c >= lim) summarize();
   endtask : wait_sig

   task wait_ready;
      int c;
      @(posedge clk_sys);
      for (c = 0; c < 20 && hreadyout !== 1'b1; c++) @(posedge clk_sys);
      if (c >= 20) begin
         check(0, 1, "bus ready");
         summarize();
      end
   endtask : wait_ready

   task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdat);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rdat = hrdata;
   endtask : ahb

   // Compares the pins and the status state with the bench's own sequence model.
   task check_pins;
      logic [31:0] st;
      logic act;
      act = m_state inside {1, 2, 3};
      repeat (2) @(posedge clk_sys);
      check(charge_on, act && !m_ext, "charging");
      check(charge_state_flag_n_oe, act && !m_done && !m_ext, "state flag");
      check(fault_flag_n_oe, m_state == 5 || m_ext, "fault flag");
      ahb(1'b0, STATUS_OFFSET, 32'h0, st);
      check(st[17:16], {!(m_state == 5 || m_ext), !(act && !m_done && !m_ext)}, "flag pins");
      if (!m_ext) begin
         check(precharge_mode, m_state == 1, "tenth current");
         check(cv_mode, m_state == 3, "voltage mode");
         check(st[5:0], 6'h01 << m_state, "status state");
      end
   endtask : check_pins

   // ******************************************
   // Main sequence
   // ******************************************
   initial begin
      resetn <= 1'b0;
      hsel <= 1'b0;
      haddr <= 32'h0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hsize <= 3'h2;
      hwdata <= 32'h0;
      current_program_pin_fault <= 1'b0;
      temp_out_of_window <= 1'b0;
      repeat (10) @(posedge clk_sys);
      check({charge_on, bias_rail_output, charge_state_flag_n_oe, fault_flag_n_oe, hreadyout, hresp,
         charge_state_flag_n_out, fault_flag_n_out}, 8'h08, "reset outputs");
      resetn <= 1'b1;
      ahb(1'b0, OSC_DIV_OFFSET, 32'h0, rd);
      check(rd, OSC, "divider reset");
      rnd = $random(seed) | 32'h100000;
      ahb(1'b1, OSC_DIV_OFFSET, rnd, rd);
      ahb(1'b0, OSC_DIV_OFFSET, 32'h0, rd);
      check(rd, {8'h0, rnd[23:0]}, "divider write");
      ahb(1'b1, OSC_DIV_OFFSET, OSC, rd);
      ahb(1'b1, 32'h40, rnd, rd);
      ahb(1'b0, 32'h40, 32'h0, rd);
      check(rd, 32'h0, "unmapped read");
      check_pins();
      check(bias_rail_output, 1'b0, "bias off");
      battery_model_inst.set_enable(1'b1);
      wait_sig(1, 1'b1, 4);
      m_state = 1;
      check_pins();
      check(bias_rail_output, 1'b1, "bias on");
      n = 1 + $unsigned($random(seed)) % 6;
      battery_model_inst.set_level(1);
      repeat (n * OSC) @(posedge clk_sys);
      battery_model_inst.set_level(0);
      repeat (8) @(posedge clk_sys);
      ahb(1'b0, STATUS_OFFSET, 32'h0, rd);
      check(rd[15:12], 4'h0, "count cleared");
      check_pins();
      battery_model_inst.set_level(1);
      repeat (55) @(posedge clk_sys);
      check(precharge_mode, 1'b1, "early exit");
      wait_sig(1, 1'b0, 12);
      m_state = 2;
      check_pins();
      battery_model_inst.set_taper(1'b1);
      repeat (8) @(posedge clk_sys);
      check(charge_state_flag_n_oe, 1'b1, "complete below recharge");
      battery_model_inst.set_taper(1'b0);
      battery_model_inst.set_level(3);
      wait_sig(2, 1'b1, 4);
      m_state = 3;
      check_pins();
      battery_model_inst.set_taper(1'b1);
      wait_sig(3, 1'b0, 4);
      m_done = 1'b1;
      check_pins();
      ahb(1'b0, TIMER_OFFSET, 32'h0, t0);
      repeat ((254 - t0[8:0]) * OSC) @(posedge clk_sys);
      check(charge_on, 1'b1, "early stop");
      wait_sig(0, 1'b0, 24);
      m_state = 4;
      check_pins();
      ahb(1'b0, STATUS_OFFSET, 32'h0, rd);
      check(rd[ST_COMPLETE_BIT], 1'b1, "complete kept");
      battery_model_inst.set_taper(1'b0);
      battery_model_inst.set_level(0);
      wait_sig(1, 1'b1, 4);
      m_state = 1;
      m_done = 1'b0;
      check_pins();
      ahb(1'b0, TIMER_OFFSET, 32'h0, rd);
      check(rd < 4, 1'b1, "timer restart");
      for (i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         if (i == 1) temp_out_of_window <= 1'b1;
         else current_program_pin_fault <= 1'b1;
         wait_sig(4, 1'b1, 4);
         m_ext = 1'b1;
         check_pins();
         ahb(1'b0, TIMER_OFFSET, 32'h0, t0);
         repeat (40) @(posedge clk_sys);
         ahb(1'b0, TIMER_OFFSET, 32'h0, rd);
         check(rd == t0, i == 1, "timer pause");
         @(posedge clk_sys);
         current_program_pin_fault <= 1'b0;
         temp_out_of_window <= 1'b0;
         wait_sig(4, 1'b0, 4);
         m_ext = 1'b0;
         check_pins();
      end
      wait_sig(4, 1'b1, 120);
      m_state = 5;
      check_pins();
      ahb(1'b0, STATUS_OFFSET, 32'h0, rd);
      check(rd[ST_TIME_FAULT_BIT], 1'b1, "time fault");
      battery_model_inst.set_level(1);
      repeat (80) @(posedge clk_sys);
      check_pins();
      battery_model_inst.set_enable(1'b0);
      m_state = 0;
      check_pins();
      check(bias_rail_output, 1'b0, "bias shut");
      ahb(1'b0, TIMER_OFFSET, 32'h0, rd);
      check(rd, 32'h0, "timer held");
      battery_model_inst.set_enable(1'b1);
      wait_sig(1, 1'b1, 4);
      m_state = 1;
      check_pins();
      wait_sig(1, 1'b0, 70);
      m_state = 2;
      check_pins();
      wait_sig(4, 1'b1, 1100);
      m_state = 5;
      check_pins();
      summarize();
   end
endmodule : tb
